// >>> hdl/scdp_ctrl.v
// Run-mode clock configuration register with APB access and clock controls.
//
// Behaviour
// - Auto gating set: sleep uses sleep set, deep sleep uses deep-sleep set.
// - Auto gating clear: sleep modes keep using the run gating set.
// - Run mode always uses the run gating set.
// - Divisor field, reset 0xf, divides by value plus one when bypassed.
// - A too-low divisor with the PLL in use reads back as the minimum.
// - Divider-use bit set routes the system clock through the divider.
// - Selecting the PLL forces use of the divider.
// - Power-down bit drives the PLL power-down input, reset 1.
// - Output-enable bit clear lets the PLL clock out, set blocks it.
// - Bypass set selects oscillator clock, clear selects PLL output.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

`include "scdp_map.vh"

module scdp_ctrl #(
	parameter GATE_W = 32
) (
	// Clock and reset
	input  wire              pclk,
	input  wire              presetn,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [11:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// Power mode and gating registers
	input  wire [1:0]        power_mode,
	input  wire [GATE_W-1:0] run_gating_regs,
	input  wire [GATE_W-1:0] sleep_gating_regs,
	input  wire [GATE_W-1:0] deep_sleep_gating_regs,
	// Clock controls
	output reg  [GATE_W-1:0] periph_gate_r,
	output reg  [1:0]        gate_sel_r,
	output reg  [3:0]        eff_divisor_r,
	output reg               sysclk_use_div_r,
	output reg               sysclk_sel_osc_r,
	output reg               pll_power_down_r,
	output reg               pll_out_enable_r
);

	// ======================================================================
	// Register fields
	reg        autogate_r;
	reg  [3:0] div_r;
	reg        usediv_r;
	reg        bypass_r;
	reg  [3:0] div_nxt;
	reg  [3:0] div_rd;
	wire       wr_en;
	wire       rd_en;
	wire       hit;
	wire [3:0] wr_div;
	wire       wr_bypass;
	wire [31:0] rd_word;
	wire [1:0]  gsel;
	wire [GATE_W-1:0] gval;

	assign hit       = (paddr == `SCDP_RMCC_OFF);
	assign wr_en     = psel & penable & pwrite & ~pready;
	assign rd_en     = psel & penable & ~pwrite & ~pready;
	assign wr_div    = pwdata[`SCDP_DIV_HI:`SCDP_DIV_LO];
	assign wr_bypass = pwdata[`SCDP_BYPASS_BIT];

	// Divisor stored as written; the reserved zero code is held off.
	always @* begin
		div_nxt = div_r;
		if (wr_en && hit) begin
			if (wr_div == `SCDP_DIV_RSVD)
				div_nxt = `SCDP_DIV_MIN_BYP;
			else
				div_nxt = wr_div;
		end
	end

	// Reads clamp to the minimum while the PLL drives the system.
	always @* begin
		if (!bypass_r && div_r < `SCDP_DIV_MIN_PLL)
			div_rd = `SCDP_DIV_MIN_PLL;
		else
			div_rd = div_r;
	end

	// Reserved fields are left as zero in the read word.
	assign rd_word = ({31'h0, autogate_r} << `SCDP_AUTOGATE_BIT)
		| ({28'h0, div_rd} << `SCDP_DIV_LO)
		| ({31'h0, usediv_r} << `SCDP_USEDIV_BIT)
		| ({31'h0, pll_power_down_r} << `SCDP_PDOWN_BIT)
		| ({31'h0, pll_out_enable_r} << `SCDP_OUTEN_BIT)
		| ({31'h0, bypass_r} << `SCDP_BYPASS_BIT);

	// ======================================================================
	// APB slave: one wait state per access, error on unmapped addresses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			if (rd_en)
				prdata <= hit ? rd_word : 32'h0;
		end
	end

	// ======================================================================
	// Register storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autogate_r       <= `SCDP_AUTOGATE_RST;
			div_r            <= `SCDP_DIV_RST;
			usediv_r         <= `SCDP_USEDIV_RST;
			pll_power_down_r <= `SCDP_PDOWN_RST;
			pll_out_enable_r <= `SCDP_OUTEN_RST;
			bypass_r         <= `SCDP_BYPASS_RST;
		end else begin
			div_r <= div_nxt;
			if (wr_en && hit) begin
				autogate_r       <= pwdata[`SCDP_AUTOGATE_BIT];
				usediv_r         <= pwdata[`SCDP_USEDIV_BIT];
				// Both must be cleared by software to run the PLL.
				pll_power_down_r <= pwdata[`SCDP_PDOWN_BIT];
				pll_out_enable_r <= pwdata[`SCDP_OUTEN_BIT];
				bypass_r         <= wr_bypass;
			end
		end
	end

	// ======================================================================
	// Clock path controls
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_divisor_r    <= `SCDP_DIV_RST;
			sysclk_use_div_r <= `SCDP_USEDIV_RST;
			sysclk_sel_osc_r <= `SCDP_BYPASS_RST;
		end else begin
			eff_divisor_r    <= div_rd;
			sysclk_use_div_r <= usediv_r | ~bypass_r;
			sysclk_sel_osc_r <= bypass_r;
		end
	end

	// ======================================================================
	// Peripheral clock gating
	scdp_gate_sel #(
		.N(GATE_W)
	) u_gate_sel (
		.auto_gating_select     (autogate_r),
		.power_mode             (power_mode),
		.run_gating_regs        (run_gating_regs),
		.sleep_gating_regs      (sleep_gating_regs),
		.deep_sleep_gating_regs (deep_sleep_gating_regs),
		.gate_sel               (gsel),
		.gate_value             (gval)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_sel_r    <= `SCDP_GSEL_RUN;
			periph_gate_r <= {GATE_W{1'b0}};
		end else begin
			gate_sel_r    <= gsel;
			periph_gate_r <= gval;
		end
	end

endmodule // scdp_ctrl

// >>> hdl/scdp_map.vh
// Register map and field constants for the run-mode clock configuration block.
`ifndef SCDP_MAP_VH
`define SCDP_MAP_VH

// ==========================================================================
// Register offsets
`define SCDP_RMCC_OFF      12'h060

// ==========================================================================
// Field positions
`define SCDP_AUTOGATE_BIT  27
`define SCDP_DIV_HI        26
`define SCDP_DIV_LO        23
`define SCDP_USEDIV_BIT    22
`define SCDP_PDOWN_BIT     13
`define SCDP_OUTEN_BIT     12
`define SCDP_BYPASS_BIT    11

// ==========================================================================
// Reset values and limits
`define SCDP_DIV_RST       4'hf
`define SCDP_DIV_MIN_PLL   4'h7
`define SCDP_DIV_RSVD      4'h0
`define SCDP_DIV_MIN_BYP   4'h1
`define SCDP_AUTOGATE_RST  1'b0
`define SCDP_USEDIV_RST    1'b0
`define SCDP_PDOWN_RST     1'b1
`define SCDP_OUTEN_RST     1'b1
`define SCDP_BYPASS_RST    1'b1

// ==========================================================================
// Power modes
`define SCDP_MODE_RUN      2'h0
`define SCDP_MODE_SLEEP    2'h1
`define SCDP_MODE_DEEP     2'h2

// ==========================================================================
// Gating register set selections
`define SCDP_GSEL_RUN      2'h0
`define SCDP_GSEL_SLEEP    2'h1
`define SCDP_GSEL_DEEP     2'h2

`endif

// >>> hdl/scdp_gate_sel.v
// Picks the peripheral clock gating register set for the current power mode.
`timescale 1ns/100ps

`include "scdp_map.vh"

module scdp_gate_sel #(
	parameter N = 32
) (
	// Control
	input  wire         auto_gating_select,
	input  wire [1:0]   power_mode,
	// Gating register sets
	input  wire [N-1:0] run_gating_regs,
	input  wire [N-1:0] sleep_gating_regs,
	input  wire [N-1:0] deep_sleep_gating_regs,
	// Result
	output reg  [1:0]   gate_sel,
	output reg  [N-1:0] gate_value
);

	always @* begin
		gate_sel   = `SCDP_GSEL_RUN;
		gate_value = run_gating_regs;
		if (auto_gating_select) begin
			if (power_mode == `SCDP_MODE_SLEEP) begin
				gate_sel   = `SCDP_GSEL_SLEEP;
				gate_value = sleep_gating_regs;
			end else if (power_mode == `SCDP_MODE_DEEP) begin
				gate_sel   = `SCDP_GSEL_DEEP;
				gate_value = deep_sleep_gating_regs;
			end
		end
		// With the select clear, sleep modes keep the run set.
	end

endmodule // scdp_gate_sel

// >>> tb/scdp_ctrl_asserts.sv
// Port assertions for the clock configuration block.
`timescale 1ns/100ps
module scdp_ctrl_asserts (
	// Bus
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic [11:0] paddr,
	input logic        pready,
	input logic        pslverr,
	// Controls
	input logic [1:0]  power_mode,
	input logic [1:0]  gate_sel_r,
	input logic [3:0]  eff_divisor_r,
	input logic        sysclk_use_div_r,
	input logic        sysclk_sel_osc_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready long");
	a_err_addr: assert property (pready |-> pslverr == (paddr != 12'h060))
		else $error("bad error flag");
	a_err_quiet: assert property (!pready |-> !pslverr)
		else $error("error flag without ready");
	a_gate_code: assert property (gate_sel_r != 2'h3)
		else $error("gate set code");
	a_run_gate: assert property (
		(power_mode == 2'h0 || power_mode == 2'h3) |=> gate_sel_r == 2'h0)
		else $error("run set");
	a_sleep_gate: assert property (
		power_mode == 2'h1 |=> gate_sel_r != 2'h2) else $error("sleep set");
	a_deep_gate: assert property (
		power_mode == 2'h2 |=> gate_sel_r != 2'h1) else $error("deep set");
	a_pll_div: assert property (
		!sysclk_sel_osc_r |-> sysclk_use_div_r && eff_divisor_r >= 4'h7)
		else $error("pll divisor");
	a_div_nonzero: assert property (eff_divisor_r != 4'h0)
		else $error("zero divisor");
	c_err: cover property (pready && pslverr);
	c_pll: cover property (!sysclk_sel_osc_r);
	c_sleep: cover property (gate_sel_r == 2'h1);
endmodule // scdp_ctrl_asserts

// >>> tb/sysclk_divider_pll_ctrl_tb.sv
// Self-checking bench for the clock configuration block.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((e) !== (a)) begin \
	$display("BAD %s exp %h got %h", n, e, a); miscompares++; end end
module sysclk_divider_pll_ctrl_tb;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic        ud, so, pd, oe, m_ag, m_ud, m_pd, m_oe, m_bp, er;
	logic [1:0]  pm, gs, eg;
	logic [3:0]  ed, m_div;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rg, sg, dg, pg, rd, rs, ex;
	int          miscompares = 0;
	int          num_checks = 0;
	scdp_ctrl u_scdp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_mode(pm), .run_gating_regs(rg), .sleep_gating_regs(sg),
		.deep_sleep_gating_regs(dg), .periph_gate_r(pg), .gate_sel_r(gs),
		.eff_divisor_r(ed), .sysclk_use_div_r(ud), .sysclk_sel_osc_r(so),
		.pll_power_down_r(pd), .pll_out_enable_r(oe));
	initial forever #4 pclk = ~pclk;
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [31:0] ew();
		logic [3:0] d;
		d = (!m_bp && m_div < 4'h7) ? 4'h7 : m_div;
		return {4'h0, m_ag, d, m_ud, 8'h00, m_pd, m_oe, m_bp, 11'h000};
	endfunction
	task automatic stop_test();
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
		miscompares += (n == 20);
		if (n == 20) stop_test();
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
		if (w && a == 12'h060) begin
			{m_ag, m_div, m_ud} = d[27:22];
			if (m_div == 4'h0) m_div = 4'h1;
			{m_pd, m_oe, m_bp} = d[13:11];
		end
	endtask
	initial begin
		rs = 32'h1c;
		{presetn, psel, penable, pwrite, paddr, pwdata, pm, rg, sg, dg} = '0;
		{m_ag, m_div, m_ud, m_pd, m_oe, m_bp} = 9'h0f7;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h064, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("slverr", 1'b1, er)
		apb(1'b1, 12'h064, 32'hffffffff);
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, 12'h060, 32'h0);
			ex = ew();
			`CHK("rmcc", ex, rd)
			`CHK("slverr", 1'b0, er)
			if (i % 4 == 3) begin
				apb(1'b0, 12'h064, 32'h0);
				`CHK("unmapped", 32'h0, rd)
				`CHK("slverr", 1'b1, er)
				apb(1'b1, 12'h064, xs());
			end
			@(posedge pclk);
			eg = (m_ag && pm != 2'h3) ? pm : 2'h0;
			`CHK("gate_sel", eg, gs)
			`CHK("gate", eg == 2'h1 ? sg : eg == 2'h2 ? dg : rg, pg)
			`CHK("ctl", {ex[26:23], m_ud | ~m_bp, ex[13:11]},
				{ed, ud, pd, oe, so})
			rg <= xs();
			sg <= xs();
			dg <= xs();
			pm <= 2'(xs());
			apb(1'b1, 12'h060, i < 2 ? {20'h0, i[0], 11'h0} : xs());
		end
		stop_test();
	end
endmodule // sysclk_divider_pll_ctrl_tb
bind scdp_ctrl scdp_ctrl_asserts u_scdp_ctrl_asserts (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .power_mode(power_mode),
	.gate_sel_r(gate_sel_r), .eff_divisor_r(eff_divisor_r),
	.sysclk_use_div_r(sysclk_use_div_r), .sysclk_sel_osc_r(sysclk_sel_osc_r));
